/* design/nv_counter_pkg.sv */
// constants shared by the non-volatile event counter and its host-side controller
// assumes a 100 MHz system clock on both ends
package nv_counter_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // bus locations
   localparam logic [3:0] ADDR_VCNT4 = 4'h0;
   localparam logic [3:0] ADDR_NV_W1 = 4'h1;
   localparam logic [3:0] ADDR_NV_W5 = 4'h5;
   localparam logic [3:0] ADDR_C16_W1 = 4'h6;
   localparam logic [3:0] ADDR_C16_W4 = 4'h9;
   localparam logic [3:0] ADDR_FLAG = 4'hA;
   localparam logic [3:0] ADDR_CRST = 4'hB;
   localparam logic [3:0] ADDR_PAD_LO = 4'hC;
   // fixed patterns and codes
   localparam logic [3:0] PAT_CRST = 4'hB;
   localparam logic [3:0] PAT_BUSY = 4'hA;
   localparam logic [3:0] UNLOCK_CODE = 4'h5;
   localparam logic [3:0] CRST_CODE = 4'h4;
   // flag register bit positions
   localparam int FLAG_BUSY_BIT = 3;
   localparam int FLAG_TAMPER_BIT = 0;
   // reset values
   localparam logic [19:0] NV_RST = 20'h0_0000;
   localparam logic [15:0] C16_RST = 16'h0000;
   // host strobe timing
   localparam int T_STROBE_NS = 300;
   localparam int T_WR_STROBE_NS = 500;
   localparam int T_LR_NS = 1500;
   localparam int T_LW_NS = 1500;
   localparam int T_WL_NS = 1550;
   localparam int T_STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_WR_STROBE_CYC = (T_WR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_LR_CYC = (T_LR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_LW_CYC = (T_LW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_WL_CYC = (T_WL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // warning hold-up and emulated eeprom programming time
   localparam int T_HOLDUP_MS = 50;
   localparam int T_PROG_US = 20;
   localparam int T_PROG_CYC = (T_PROG_US * 1000) / CLK_PERIOD_NS;
   // host command codes
   typedef enum logic [1:0] {CMD_NONE, CMD_READ, CMD_WRITE} cmd_t;
endpackage

/* design/nv_bus_if.sv */
// strobe bus between host and counter; active-low read/write strobes, high-active latch strobe, 4 shared data lines
// the interface resolves the shared lines from the two enables: device first, F when neither drives
`timescale 1ns/1ns
interface nv_bus_if;
   logic ale; // address latch strobe, high active
   logic rd_n; // read strobe
   logic wr_n; // write strobe
   logic [3:0] host_dout; // host drive value
   logic host_oe; // host drives the lines
   logic [3:0] dev_dout; // device drive value
   logic dev_oe; // device drives the lines
   logic [3:0] shared_data_lines; // resolved line level
   logic low_supply_n; // low-supply warning
   logic count_pulse_in; // counted events
   assign shared_data_lines = dev_oe ? dev_dout : (host_oe ? host_dout : 4'hF);
   modport device (input ale, input rd_n, input wr_n, input shared_data_lines,
      input low_supply_n, input count_pulse_in, output dev_dout, output dev_oe);
   modport host (output ale, output rd_n, output wr_n, output host_dout, output host_oe,
      input shared_data_lines);
endinterface

/* design/nv_counter_dev.sv */
// counter end: 4-bit volatile counter with eeprom-backed 20-bit count, 16-bit
// volatile counter, flag register, scratch pad, strobe bus slave
// assumes bus pins and count input are asynchronous; synchronised here
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module nv_counter_dev #(
   parameter int PROG_CYC = nv_counter_pkg::T_PROG_CYC
) (
   input wire logic sys_clk, // system clock
   input wire logic rstn, // async reset, power-up
   input wire logic clk_en, // freezes all state while low
   nv_bus_if.device bus, // host bus
   output logic busy // eeprom programming in progress
);
   typedef enum {ARM_IDLE, ARM_GOT_A, ARM_ARMED, ARM_GOT_ADDR} arm_t;
   logic [2:0] ale_s, rd_s, wr_s, cnt_s;
   logic [3:0] d_s1, d_s2;
   logic ale_rise, rd_fall, rd_rise, wr_rise, cnt_rise;
   logic [3:0] addr_r;
   logic [3:0] vcnt4_r;
   logic [19:0] nv_r;
   logic [15:0] c16_r;
   logic tamper_r;
   logic [3:0] pad_r [4];
   logic [3:0] dout_r;
   logic oe_r;
   arm_t arm_r, arm_nxt;
   logic [31:0] prog_cnt_r;
   logic bkup_req, pad_req, arm_write;
   logic [3:0] rdata;
   // a-f are the guarded locations: frozen while programming runs
   function automatic logic is_guarded(input logic [3:0] a);
      return a >= nv_counter_pkg::ADDR_FLAG;
   endfunction
   // c-f hold the scratch pad; only these take data from a write
   function automatic logic is_pad(input logic [3:0] a);
      return a >= nv_counter_pkg::ADDR_PAD_LO;
   endfunction
   // nibble idx of a counter laid out least significant word first
   function automatic logic [3:0] nibble(input logic [19:0] v, input logic [3:0] idx);
      return v[4 * idx +: 4];
   endfunction
   // two-flop synchronisers; only the second stage and later are looked at
   // strobe and count stages reset to each pin's idle level, so no false edge follows reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ale_s <= 3'b000;
         rd_s <= 3'b111;
         wr_s <= 3'b111;
         cnt_s <= 3'b000;
         d_s1 <= 4'h0;
         d_s2 <= 4'h0;
      end else if (clk_en) begin
         ale_s <= {ale_s[1:0], bus.ale};
         rd_s <= {rd_s[1:0], bus.rd_n};
         wr_s <= {wr_s[1:0], bus.wr_n};
         cnt_s <= {cnt_s[1:0], bus.count_pulse_in};
         d_s1 <= bus.shared_data_lines;
         d_s2 <= d_s1;
      end
   end
   assign ale_rise = ale_s[1] & ~ale_s[2];
   assign rd_fall = ~rd_s[1] & rd_s[2];
   assign rd_rise = rd_s[1] & ~rd_s[2];
   assign wr_rise = wr_s[1] & ~wr_s[2];
   assign cnt_rise = cnt_s[1] & ~cnt_s[2];
   // address capture at end of ale pulse would miss hold; take it on the rise
   // the sequencer below looks at the same d_s2 sample, so both agree
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         addr_r <= 4'h0;
      end else if (clk_en && ale_rise) begin
         addr_r <= d_s2;
      end
   end
   // unlock sequencer; any other bus operation drops back to idle
   // no half-done sequence survives: a read in between disarms as well
   assign arm_write = (arm_r == ARM_GOT_ADDR) && wr_rise;
   always_comb begin
      arm_nxt = arm_r;
      unique case (arm_r)
         ARM_IDLE: if (ale_rise && d_s2 == nv_counter_pkg::ADDR_FLAG) arm_nxt = ARM_GOT_A;
         ARM_GOT_A: begin
            if (wr_rise && d_s2 == nv_counter_pkg::UNLOCK_CODE) arm_nxt = ARM_ARMED;
            else if (wr_rise || rd_fall || ale_rise) arm_nxt = ARM_IDLE;
         end
         ARM_ARMED: begin
            if (ale_rise) arm_nxt = ARM_GOT_ADDR;
            else if (wr_rise || rd_fall) arm_nxt = ARM_IDLE;
         end
         ARM_GOT_ADDR: begin
            if (wr_rise || rd_fall || ale_rise) arm_nxt = ARM_IDLE;
         end
      endcase
   end
   // power-up lands in idle, so any write needs the full unlock first
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         arm_r <= ARM_IDLE;
      end else if (clk_en) begin
         arm_r <= arm_nxt;
      end
   end
   // pad writes land only at c-f, and not while programming
   assign pad_req = arm_write && is_pad(addr_r) && !(busy && is_guarded(addr_r));
   // counters: 4-bit volatile, backup on its overflow, 16-bit volatile
   // the backup only moves on the low counter's carry: one cell write per 16 events
   assign bkup_req = cnt_rise && vcnt4_r == 4'hF;
   // carry out of the 20-bit count lands in tamper; only reset clears it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         vcnt4_r <= 4'h0;
         nv_r <= nv_counter_pkg::NV_RST;
         tamper_r <= 1'b0;
      end else if (clk_en && cnt_rise) begin
         vcnt4_r <= vcnt4_r + 4'h1;
         if (bkup_req) begin
            {tamper_r, nv_r} <= {tamper_r, 20'h0_0000} | ({1'b0, nv_r} + 21'h0_0001);
         end
      end
   end
   // a counter reset wins over an event in the same cycle; that event is lost
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         c16_r <= nv_counter_pkg::C16_RST;
      end else if (clk_en) begin
         if (arm_write && addr_r == nv_counter_pkg::ADDR_CRST && !(busy && is_guarded(addr_r))
               && d_s2 == nv_counter_pkg::CRST_CODE) begin
            c16_r <= nv_counter_pkg::C16_RST;
         end else if (cnt_rise) begin
            c16_r <= c16_r + 16'h0001;
         end
      end
   end
   // scratch pad; a write starts an emulated programming interval
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 4; i++) pad_r[i] <= 4'h0;
      end else if (clk_en && pad_req) begin
         pad_r[addr_r[1:0]] <= d_s2;
      end
   end
   // busy timer covers pad programming and each counter backup
   // a new request restarts the interval rather than queueing behind it
   // the interval is a parameter: the default models a real cell, tests shorten it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prog_cnt_r <= 32'h0000_0000;
      end else if (clk_en) begin
         if (pad_req || bkup_req) prog_cnt_r <= 32'(PROG_CYC);
         else if (prog_cnt_r != 32'h0000_0000) prog_cnt_r <= prog_cnt_r - 32'h0000_0001;
      end
   end
   assign busy = prog_cnt_r != 32'h0000_0000;
   // read mux; word 1 of each counter is its least significant nibble
   // busy pattern first: a-f must never show half-programmed contents
   always_comb begin
      rdata = 4'h0;
      if (busy && is_guarded(addr_r)) rdata = nv_counter_pkg::PAT_BUSY;
      else if (addr_r == nv_counter_pkg::ADDR_CRST) rdata = nv_counter_pkg::PAT_CRST;
      else if (addr_r == nv_counter_pkg::ADDR_FLAG) rdata = {1'b0, 2'b00, tamper_r};
      else if (is_pad(addr_r)) rdata = pad_r[addr_r[1:0]];
      else if (addr_r >= nv_counter_pkg::ADDR_C16_W1) begin
         rdata = nibble({4'h0, c16_r}, addr_r - nv_counter_pkg::ADDR_C16_W1);
      end else if (addr_r >= nv_counter_pkg::ADDR_NV_W1) begin
         rdata = nibble(nv_r, addr_r - nv_counter_pkg::ADDR_NV_W1);
      end else rdata = vcnt4_r;
   end
   // drive only inside the synchronised read strobe; data settles well before its rise
   // the enable also drops on the synchronised strobe: release lags its rise by two cycles
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dout_r <= 4'h0;
         oe_r <= 1'b0;
      end else if (clk_en) begin
         if (rd_fall) begin
            dout_r <= rdata;
            oe_r <= 1'b1;
         end else if (rd_rise) begin
            oe_r <= 1'b0;
         end
      end
   end
   // low-supply warning needs no action: the backup is always current
   // limitation: a pad write already started still needs its full programming time
   assign bus.dev_dout = dout_r;
   assign bus.dev_oe = oe_r & ~rd_s[1];
endmodule // nv_counter_dev

/* design/nv_host_ctl.sv */
// host end: turns single read/write commands into timed strobe sequences,
// and writes via the unlock sequence
// assumes commands come from logic on sys_clk
`timescale 1ns/1ns
module nv_host_ctl (
   input wire logic sys_clk, // system clock
   input wire logic rstn, // async reset
   input wire logic clk_en, // freezes all state while low
   input wire nv_counter_pkg::cmd_t cmd, // command, taken when ready
   input wire logic [3:0] cmd_addr, // target location
   input wire logic [3:0] cmd_data, // write data
   output logic ready, // idle, accepts a command
   output logic [3:0] rd_data, // read result
   output logic rd_valid, // one-cycle pulse with rd_data
   nv_bus_if.host bus // counter bus
);
   typedef enum {H_IDLE, H_ALE, H_GAP_LR, H_RD, H_WR, H_GAP_LW, H_GAP_END} hst_t;
   hst_t st_r;
   logic [15:0] tmr_r;
   logic [1:0] step_r; // write pass: 0 unlock (a, 5), 2 target (addr, data)
   logic is_wr_r;
   logic [3:0] addr_r, data_r;
   logic [3:0] d_s1, d_s2;
   // read data synchronised from the shared lines
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         d_s1 <= 4'h0;
         d_s2 <= 4'h0;
      end else if (clk_en) begin
         d_s1 <= bus.shared_data_lines;
         d_s2 <= d_s1;
      end
   end
   // a command is only taken once the closing gap has run out
   assign ready = st_r == H_IDLE && tmr_r == 16'h0000;
   // sequencer; each phase lasts its loaded tmr_r value plus one cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= H_IDLE;
         tmr_r <= 16'h0000;
         step_r <= 2'b00;
         is_wr_r <= 1'b0;
         addr_r <= 4'h0;
         data_r <= 4'h0;
         rd_data <= 4'h0;
         rd_valid <= 1'b0;
      end else if (clk_en) begin
         rd_valid <= 1'b0;
         if (tmr_r != 16'h0000) tmr_r <= tmr_r - 16'h0001;
         else begin
            unique case (st_r)
               H_IDLE: if (cmd != nv_counter_pkg::CMD_NONE) begin
                  is_wr_r <= cmd == nv_counter_pkg::CMD_WRITE;
                  addr_r <= cmd_addr;
                  data_r <= cmd_data;
                  step_r <= 2'b00;
                  st_r <= H_ALE;
                  tmr_r <= 16'(nv_counter_pkg::T_STROBE_CYC + 2);
               end
               H_ALE: begin
                  st_r <= H_GAP_LR;
                  tmr_r <= 16'(is_wr_r ? nv_counter_pkg::T_LW_CYC : nv_counter_pkg::T_LR_CYC);
               end
               H_GAP_LR: begin
                  st_r <= is_wr_r ? H_WR : H_RD;
                  tmr_r <= 16'(is_wr_r ? nv_counter_pkg::T_WR_STROBE_CYC + 2
                     : nv_counter_pkg::T_STROBE_CYC + 2);
               end
               H_RD: begin
                  rd_data <= d_s2;
                  rd_valid <= 1'b1;
                  st_r <= H_GAP_END;
                  tmr_r <= 16'(nv_counter_pkg::T_LR_CYC);
               end
               H_WR: begin
                  st_r <= H_GAP_LW;
                  tmr_r <= 16'(nv_counter_pkg::T_WL_CYC);
               end
               H_GAP_LW: begin
                  step_r <= step_r + 2'b10;
                  st_r <= step_r[1] ? H_IDLE : H_ALE;
                  tmr_r <= 16'(nv_counter_pkg::T_STROBE_CYC + 2);
               end
               H_GAP_END: st_r <= H_IDLE;
            endcase
         end
      end
   end
   // write = unlock (a, 5) then (addr, data); steps 0/1 or 2/3
   always_comb begin
      bus.ale = st_r == H_ALE;
      bus.rd_n = st_r != H_RD;
      bus.wr_n = st_r != H_WR;
      bus.host_oe = is_wr_r ? st_r != H_IDLE && st_r != H_GAP_END
         : st_r == H_ALE || st_r == H_GAP_LR;
      if (is_wr_r && !step_r[1]) begin
         bus.host_dout = (st_r == H_ALE) ? nv_counter_pkg::ADDR_FLAG
            : nv_counter_pkg::UNLOCK_CODE;
      end else begin
         bus.host_dout = (st_r == H_ALE) ? addr_r : data_r;
      end
   end
endmodule // nv_host_ctl

/* verification/nv_bus_monitor.sv */
// checker for the strobe bus between host controller and counter
// assumes it is instantiated beside the interface, one clock, async low reset
`timescale 1ns/1ns
module nv_bus_monitor (
   input wire logic sys_clk, // clock
   input wire logic rstn, // async reset
   input wire logic ale, // latch strobe
   input wire logic rd_n, // read strobe
   input wire logic wr_n, // write strobe
   input wire logic [3:0] host_dout, // host value
   input wire logic host_oe, // host drives
   input wire logic [3:0] dev_dout, // device value
   input wire logic dev_oe, // device drives
   input wire logic [3:0] shared_data_lines // resolved lines
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic [3:0] lat_r;
   logic armed_r;
   int ale_w_r, rd_w_r, wr_w_r, s_ale_r, s_rd_r, s_wr_r;
   // strobe widths and spacing; spacing starts large so the first strobe is not judged too soon
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ale_w_r <= 0; rd_w_r <= 0; wr_w_r <= 0;
         s_ale_r <= 1000; s_rd_r <= 1000; s_wr_r <= 1000;
      end else begin
         ale_w_r <= ale ? ale_w_r + 1 : 0;
         rd_w_r <= !rd_n ? rd_w_r + 1 : 0;
         wr_w_r <= !wr_n ? wr_w_r + 1 : 0;
         s_ale_r <= ale ? 0 : s_ale_r + 1;
         s_rd_r <= !rd_n ? 0 : s_rd_r + 1;
         s_wr_r <= !wr_n ? 0 : s_wr_r + 1;
      end
   end
   // latched address and unlock phase, as the counter should see them
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lat_r <= 4'h0;
         armed_r <= 1'b0;
      end else begin
         if (ale) lat_r <= shared_data_lines;
         if (!rd_n) armed_r <= 1'b0;
         else if ($rose(wr_n)) armed_r <= !armed_r;
      end
   end
   property p_dev_release;
      dev_oe |-> !rd_n || !$past(rd_n) || !$past(rd_n, 2);
   endproperty
   a_dev_release: assert property (p_dev_release) else $error("device drives outside read");
   property p_no_clash;
      !(dev_oe && host_oe);
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive the lines");
   property p_strobe_width;
      ($fell(ale) |-> ale_w_r >= nv_counter_pkg::T_STROBE_CYC) and
      ($rose(rd_n) |-> rd_w_r >= nv_counter_pkg::T_STROBE_CYC);
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("latch or read strobe short");
   property p_wr_width;
      $rose(wr_n) |-> wr_w_r >= nv_counter_pkg::T_WR_STROBE_CYC;
   endproperty
   a_wr_width: assert property (p_wr_width) else $error("write strobe short");
   property p_latch_to_strobe;
      $fell(rd_n) || $fell(wr_n) |-> s_ale_r >= nv_counter_pkg::T_LR_CYC;
   endproperty
   a_latch_to_strobe: assert property (p_latch_to_strobe) else $error("strobe too soon");
   property p_strobe_to_latch;
      $rose(ale) |-> s_rd_r >= nv_counter_pkg::T_LR_CYC && s_wr_r >= nv_counter_pkg::T_WL_CYC;
   endproperty
   a_strobe_to_latch: assert property (p_strobe_to_latch) else $error("latch too soon");
   property p_fixed_b;
      $rose(rd_n) && lat_r == nv_counter_pkg::ADDR_CRST |->
         $past(shared_data_lines) == nv_counter_pkg::PAT_CRST;
   endproperty
   a_fixed_b: assert property (p_fixed_b) else $error("location b not fixed pattern");
   property p_flag_idle;
      $rose(rd_n) && lat_r == nv_counter_pkg::ADDR_FLAG && !$past(shared_data_lines[3]) |->
         $past(shared_data_lines[2:1]) == 2'b00;
   endproperty
   a_flag_idle: assert property (p_flag_idle) else $error("flag middle bits not low");
   property p_drive_soon;
      $fell(rd_n) |-> ##[1:8] dev_oe;
   endproperty
   a_drive_soon: assert property (p_drive_soon) else $error("read data not driven");
   property p_unlock_first;
      $rose(wr_n) && !armed_r |-> lat_r == nv_counter_pkg::ADDR_FLAG &&
         $past(host_dout) == nv_counter_pkg::UNLOCK_CODE;
   endproperty
   a_unlock_first: assert property (p_unlock_first) else $error("write without unlock");
endmodule // nv_bus_monitor

/* verification/tb.sv */
// self-checking bench: host controller and counter joined by the bus interface
// assumes 100 MHz clock; programming time shortened so busy reads can be seen
`timescale 1ns/1ns
module tb;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   nv_counter_pkg::cmd_t cmd = nv_counter_pkg::CMD_NONE;
   logic [3:0] cmd_addr = 4'h0;
   logic [3:0] cmd_data = 4'h0;
   logic ready, rd_valid, busy;
   logic [3:0] rd_data;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   nv_bus_if nv_bus_if_i();
   nv_counter_dev #(.PROG_CYC(600)) nv_counter_dev_i (.sys_clk(sys_clk), .rstn(rstn),
      .clk_en(1'b1), .bus(nv_bus_if_i), .busy(busy));
   nv_host_ctl nv_host_ctl_i (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .cmd(cmd),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .ready(ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .bus(nv_bus_if_i));
   nv_bus_monitor nv_bus_monitor_i (.sys_clk(sys_clk), .rstn(rstn), .ale(nv_bus_if_i.ale),
      .rd_n(nv_bus_if_i.rd_n), .wr_n(nv_bus_if_i.wr_n), .host_dout(nv_bus_if_i.host_dout),
      .host_oe(nv_bus_if_i.host_oe), .dev_dout(nv_bus_if_i.dev_dout),
      .dev_oe(nv_bus_if_i.dev_oe), .shared_data_lines(nv_bus_if_i.shared_data_lines));
   always #5 sys_clk = ~sys_clk;
   // hang guard: the whole run needs well under this many cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails = fails + 1;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [3:0] seen, logic [3:0] exp);
      n_checks++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   // one command; returns when the controller is idle again or the read result is in
   task automatic issue(nv_counter_pkg::cmd_t c, logic [3:0] a, logic [3:0] d);
      int n;
      while (ready !== 1'b1) tick();
      @(posedge sys_clk);
      cmd <= c;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge sys_clk);
      cmd <= nv_counter_pkg::CMD_NONE;
      #1;
      for (n = 0; n < 3000; n++) begin
         if (c == nv_counter_pkg::CMD_READ ? rd_valid === 1'b1 : ready === 1'b1) break;
         tick();
      end
      chk("command done", {3'b000, n < 3000}, 4'h1);
   endtask
   task automatic rd(logic [3:0] a, logic [3:0] exp, string nm);
      issue(nv_counter_pkg::CMD_READ, a, 4'h0);
      chk(nm, rd_data, exp);
   endtask
   task automatic wr(logic [3:0] a, logic [3:0] d);
      issue(nv_counter_pkg::CMD_WRITE, a, d);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) tick();
   endtask
   task automatic t_fixed();
      rd(nv_counter_pkg::ADDR_CRST, nv_counter_pkg::PAT_CRST, "loc b");
      rd(nv_counter_pkg::ADDR_FLAG, 4'h0, "flag idle");
      rd(nv_counter_pkg::ADDR_VCNT4, 4'h0, "count at start");
   endtask
   // counter locations are read-only even through a full unlock
   task automatic t_refuse();
      wr(4'h3, 4'h7);
      rd(4'h3, 4'h0, "loc 3 after write");
      wr(nv_counter_pkg::ADDR_C16_W4, 4'h9);
      rd(nv_counter_pkg::ADDR_C16_W4, 4'h0, "loc 9 after write");
      rd(nv_counter_pkg::ADDR_PAD_LO + 4'h3, 4'h0, "pad f untouched");
   endtask
   // each pad write starts programming, so the flag read right after sees the busy pattern
   task automatic t_pad();
      for (int i = 0; i < 4; i++) begin
         wr(nv_counter_pkg::ADDR_PAD_LO + 4'(i), 4'(i) ^ 4'h6);
         rd(nv_counter_pkg::ADDR_FLAG, nv_counter_pkg::PAT_BUSY, "flag busy");
         wait_idle();
      end
      for (int i = 0; i < 4; i++)
         rd(nv_counter_pkg::ADDR_PAD_LO + 4'(i), 4'(i) ^ 4'h6, "pad word");
   endtask
   // 17 events: one overflow of the low counter, one backup step
   task automatic t_count();
      for (int i = 0; i < 17; i++) begin
         repeat (6) @(posedge sys_clk);
         nv_bus_if_i.count_pulse_in <= 1'b1;
         repeat (6) @(posedge sys_clk);
         nv_bus_if_i.count_pulse_in <= 1'b0;
      end
      tick();
      wait_idle();
      rd(nv_counter_pkg::ADDR_VCNT4, 4'h1, "low count");
      rd(nv_counter_pkg::ADDR_NV_W1, 4'h1, "backup word 1");
      rd(4'h2, 4'h0, "backup word 2");
      rd(nv_counter_pkg::ADDR_C16_W1 + 4'h1, 4'h1, "16-bit word 2");
      wr(nv_counter_pkg::ADDR_CRST, nv_counter_pkg::CRST_CODE);
      rd(nv_counter_pkg::ADDR_C16_W1, 4'h0, "16-bit word 1 cleared");
      rd(nv_counter_pkg::ADDR_C16_W1 + 4'h1, 4'h0, "16-bit word 2 cleared");
      rd(nv_counter_pkg::ADDR_NV_W1, 4'h1, "backup kept");
      rd(nv_counter_pkg::ADDR_CRST, nv_counter_pkg::PAT_CRST, "loc b after reset");
      @(posedge sys_clk);
      nv_bus_if_i.low_supply_n <= 1'b0;
      rd(nv_counter_pkg::ADDR_NV_W1, 4'h1, "backup after warning");
   endtask
   initial begin
      nv_bus_if_i.low_supply_n = 1'b1;
      nv_bus_if_i.count_pulse_in = 1'b0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      t_fixed();
      t_refuse();
      t_pad();
      t_count();
      wrap_up();
   end
endmodule // tb
